/* File: src/vrzm_pkg.sv */
package vrzm_pkg;

   typedef logic [7:0] vrzm_byte_type;

   // Register offsets
   localparam vrzm_byte_type VRZM_VOL_TARGET_OFFS = 8'h4c;
   localparam vrzm_byte_type VRZM_RAMP_CTRL_OFFS  = 8'h4e;
   localparam vrzm_byte_type VRZM_EMERG_CTRL_OFFS = 8'h4f;
   localparam vrzm_byte_type VRZM_MUTE_CTRL_OFFS  = 8'h50;
   localparam vrzm_byte_type VRZM_RUN_TIME_OFFS   = 8'h51;
   localparam vrzm_byte_type VRZM_STATUS_OFFS     = 8'h52;
   localparam vrzm_byte_type VRZM_LEFT_VOL_OFFS   = 8'h44;
   localparam vrzm_byte_type VRZM_RIGHT_VOL_OFFS  = 8'h45;

   // Reset values
   localparam vrzm_byte_type VRZM_VOL_TARGET_RST = 8'h30;
   localparam vrzm_byte_type VRZM_RAMP_CTRL_RST  = 8'h33;
   localparam vrzm_byte_type VRZM_EMERG_CTRL_RST = 8'h30;
   localparam vrzm_byte_type VRZM_MUTE_CTRL_RST  = 8'h07;
   localparam vrzm_byte_type VRZM_RUN_TIME_RST   = 8'h00;

   // Field positions
   localparam int unsigned VRZM_DOWN_RATE_LSB  = 6;
   localparam int unsigned VRZM_DOWN_STEP_LSB  = 4;
   localparam int unsigned VRZM_UP_RATE_LSB    = 2;
   localparam int unsigned VRZM_UP_STEP_LSB    = 0;
   localparam int unsigned VRZM_EMERG_RATE_LSB = 6;
   localparam int unsigned VRZM_EMERG_STEP_LSB = 4;
   localparam int unsigned VRZM_LINK_BIT       = 2;
   localparam int unsigned VRZM_RIGHT_EN_BIT   = 1;
   localparam int unsigned VRZM_LEFT_EN_BIT    = 0;
   localparam int unsigned VRZM_RUN_LEFT_LSB   = 4;
   localparam int unsigned VRZM_RUN_RIGHT_LSB  = 0;

   // Rate codes
   localparam logic [1:0] VRZM_RATE_EVERY1  = 2'h0;
   localparam logic [1:0] VRZM_RATE_EVERY2  = 2'h1;
   localparam logic [1:0] VRZM_RATE_EVERY4  = 2'h2;
   localparam logic [1:0] VRZM_RATE_INSTANT = 2'h3;

   // Step size in half-dB code units, indexed by step code
   localparam vrzm_byte_type VRZM_STEP_UNITS [4] = '{8'h08, 8'h04, 8'h02, 8'h01};

   localparam vrzm_byte_type VRZM_UNITY_CODE = 8'h30;
   localparam vrzm_byte_type VRZM_MUTE_CODE  = 8'hff;

   // Zero-sample run lengths in sample periods (times at 96 kHz)
   localparam logic [18:0] VRZM_ZERO_RUN_LEN [8] = '{19'h00450, 19'h013e0, 19'h027f0,
      19'h063f0, 19'h0c8a0, 19'h18f60, 19'h3e760, 19'h7cec0};

   typedef enum logic [1:0] {
      VRZM_HOLD   = 2'b00,
      VRZM_SOFTER = 2'b01,
      VRZM_LOUDER = 2'b11
   } vrzm_ramp_state_type;

endpackage

/* File: src/vrzm_zero_run.sv */
`timescale 1ns/1ps
`default_nettype none
module vrzm_zero_run
   import vrzm_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Sample stream status
   input  wire logic       sample_tick,
   input  wire logic       sample_zero,
   input  wire logic [2:0] time_sel,
   // Run reached
   output logic            run_done
);

   logic [18:0] count_reg;
   logic [18:0] count_next;
   logic        done_reg;
   logic        done_next;

   always_comb
   begin
      count_next = count_reg;
      if (sample_tick)
      begin
         if (!sample_zero)
            count_next = 19'h00000;
         else if (count_reg < VRZM_ZERO_RUN_LEN[time_sel])
            count_next = count_reg + 19'h00001;
      end
      done_next = (count_next >= VRZM_ZERO_RUN_LEN[time_sel]);
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         count_reg <= 19'h00000;
         done_reg  <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         done_reg  <= done_next;
      end
   end

   assign run_done = done_reg;

endmodule
`default_nettype wire

/* File: src/vrzm_ramp_step.sv */
`timescale 1ns/1ps
`default_nettype none
module vrzm_ramp_step
   import vrzm_pkg::*;
(
   // Present and wanted level
   input  wire logic [7:0] cur_code,
   input  wire logic [7:0] goal_code,
   input  wire logic [1:0] step_sel,
   // Level after one update
   output logic      [7:0] stepped_code
);

   logic [7:0] gap;
   logic [7:0] step;

   always_comb
   begin
      step = VRZM_STEP_UNITS[step_sel];
      if (cur_code < goal_code)
      begin
         gap          = goal_code - cur_code;
         stepped_code = (gap <= step) ? goal_code : cur_code + step;
      end
      else
      begin
         gap          = cur_code - goal_code;
         stepped_code = (gap <= step) ? goal_code : cur_code - step;
      end
   end

endmodule
`default_nettype wire

/* File: src/vrzm_top.sv */
`timescale 1ns/1ps
`default_nettype none
module vrzm_top
   import vrzm_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Sample timing and data status
   input  wire logic       sample_tick,
   input  wire logic       left_sample_zero,
   input  wire logic       right_sample_zero,
   // Clock error or power loss
   input  wire logic       emergency_ramp,
   // Applied volume codes
   output logic      [7:0] left_volume,
   output logic      [7:0] right_volume,
   // Mute and ramp state
   output logic            left_auto_muted,
   output logic            right_auto_muted,
   output logic            ramp_active
);

   // Control registers
   logic [7:0] target_reg;
   logic [7:0] target_next;
   logic [7:0] ramp_ctrl_reg;
   logic [7:0] ramp_ctrl_next;
   logic [7:0] emerg_ctrl_reg;
   logic [7:0] emerg_ctrl_next;
   logic [7:0] mute_ctrl_reg;
   logic [7:0] mute_ctrl_next;
   logic [7:0] run_time_reg;
   logic [7:0] run_time_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // Sample pacing and fault input
   logic [1:0] phase_reg;
   logic [1:0] phase_next;
   logic       emerg_reg;
   logic       emerg_next;

   // Auto-mute
   wire logic [1:0] run_done;
   logic      [1:0] eligible;
   logic      [1:0] mute_reg;
   logic      [1:0] mute_next;
   logic            active_reg;
   logic            active_next;

   // Field views
   logic [1:0] down_rate;
   logic [1:0] down_step;
   logic [1:0] up_rate;
   logic [1:0] up_step;
   logic [1:0] emerg_rate;
   logic [1:0] emerg_step;
   logic [1:0] chan_enable;
   logic       chan_link;
   logic [7:0] status_byte;

   assign down_rate   = ramp_ctrl_reg[VRZM_DOWN_RATE_LSB +: 2];
   assign down_step   = ramp_ctrl_reg[VRZM_DOWN_STEP_LSB +: 2];
   assign up_rate     = ramp_ctrl_reg[VRZM_UP_RATE_LSB +: 2];
   assign up_step     = ramp_ctrl_reg[VRZM_UP_STEP_LSB +: 2];
   assign emerg_rate  = emerg_ctrl_reg[VRZM_EMERG_RATE_LSB +: 2];
   assign emerg_step  = emerg_ctrl_reg[VRZM_EMERG_STEP_LSB +: 2];
   assign chan_enable = {mute_ctrl_reg[VRZM_RIGHT_EN_BIT], mute_ctrl_reg[VRZM_LEFT_EN_BIT]};
   assign chan_link   = mute_ctrl_reg[VRZM_LINK_BIT];

   // True on a sample tick that falls on the selected update cadence; always true for the instant rate
   function automatic logic rate_due(input logic [1:0] rate, input logic [1:0] phase,
                                     input logic tick);
      logic due;
      due = 1'b0;
      unique case (rate)
         VRZM_RATE_EVERY1  : due = tick;
         VRZM_RATE_EVERY2  : due = tick && (phase[0] == 1'b0);
         VRZM_RATE_EVERY4  : due = tick && (phase == 2'h0);
         VRZM_RATE_INSTANT : due = 1'b1;
      endcase
      return due;
   endfunction

   // Register writes
   always_comb
   begin
      target_next     = target_reg;
      ramp_ctrl_next  = ramp_ctrl_reg;
      emerg_ctrl_next = emerg_ctrl_reg;
      mute_ctrl_next  = mute_ctrl_reg;
      run_time_next   = run_time_reg;
      if (reg_wr)
      begin
         unique case (reg_addr)
            VRZM_VOL_TARGET_OFFS : target_next = reg_wdata;
            VRZM_RAMP_CTRL_OFFS  : ramp_ctrl_next = reg_wdata;
            VRZM_EMERG_CTRL_OFFS : emerg_ctrl_next = reg_wdata;
            VRZM_MUTE_CTRL_OFFS  : mute_ctrl_next = reg_wdata;
            VRZM_RUN_TIME_OFFS   : run_time_next = reg_wdata;
            default              : ;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         target_reg     <= VRZM_VOL_TARGET_RST;
         ramp_ctrl_reg  <= VRZM_RAMP_CTRL_RST;
         emerg_ctrl_reg <= VRZM_EMERG_CTRL_RST;
         mute_ctrl_reg  <= VRZM_MUTE_CTRL_RST;
         run_time_reg   <= VRZM_RUN_TIME_RST;
      end
      else
      begin
         target_reg     <= target_next;
         ramp_ctrl_reg  <= ramp_ctrl_next;
         emerg_ctrl_reg <= emerg_ctrl_next;
         mute_ctrl_reg  <= mute_ctrl_next;
         run_time_reg   <= run_time_next;
      end
   end

   // Register reads, data valid only in the cycle after the strobe
   assign status_byte = {3'h0, emerg_reg, (g_chan[1].state_reg != VRZM_HOLD),
                         (g_chan[0].state_reg != VRZM_HOLD), mute_reg};

   always_comb
   begin
      rdata_next = 8'h00;
      if (reg_rd)
      begin
         unique case (reg_addr)
            VRZM_VOL_TARGET_OFFS : rdata_next = target_reg;
            VRZM_RAMP_CTRL_OFFS  : rdata_next = ramp_ctrl_reg;
            VRZM_EMERG_CTRL_OFFS : rdata_next = emerg_ctrl_reg;
            VRZM_MUTE_CTRL_OFFS  : rdata_next = mute_ctrl_reg;
            VRZM_RUN_TIME_OFFS   : rdata_next = run_time_reg;
            VRZM_STATUS_OFFS     : rdata_next = status_byte;
            VRZM_LEFT_VOL_OFFS   : rdata_next = g_chan[0].vol_reg;
            VRZM_RIGHT_VOL_OFFS  : rdata_next = g_chan[1].vol_reg;
            default              : rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end

   // Sample-period phase shared by both channels
   always_comb
   begin
      phase_next = phase_reg;
      if (sample_tick)
         phase_next = phase_reg + 2'h1;
      emerg_next = emergency_ramp;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         phase_reg <= 2'h0;
         emerg_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= phase_next;
         emerg_reg <= emerg_next;
      end
   end

   // Auto-mute decision
   always_comb
   begin
      eligible = run_done & chan_enable;
      if (chan_link)
         mute_next = {2{&eligible}};
      else
         mute_next = eligible;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         mute_reg <= 2'h0;
      else
         mute_reg <= mute_next;
   end

   // Per-channel zero detection and volume ramp
   for (genvar ch = 0; ch < 2; ch++)
   begin : g_chan
      logic                [7:0] goal;
      logic                [7:0] stepped;
      logic                [1:0] rate;
      logic                [1:0] step;
      logic                      due;
      logic                [7:0] vol_reg;
      logic                [7:0] vol_next;
      vrzm_ramp_state_type       state_reg;
      vrzm_ramp_state_type       state_next;

      vrzm_zero_run u_zero_run (
         .core_clk    (core_clk),
         .reset       (reset),
         .sample_tick (sample_tick),
         .sample_zero ((ch == 0) ? left_sample_zero : right_sample_zero),
         .time_sel    ((ch == 0) ? run_time_reg[VRZM_RUN_LEFT_LSB +: 3]
                                 : run_time_reg[VRZM_RUN_RIGHT_LSB +: 3]),
         .run_done    (run_done[ch])
      );

      vrzm_ramp_step u_ramp_step (
         .cur_code     (vol_reg),
         .goal_code    (goal),
         .step_sel     (step),
         .stepped_code (stepped)
      );

      always_comb
      begin
         // Higher code is quieter; a fault or auto-mute drives toward mute
         goal = (mute_reg[ch] || emerg_reg) ? VRZM_MUTE_CODE : target_reg;
         if (goal > vol_reg)
         begin
            rate = emerg_reg ? emerg_rate : down_rate;
            step = emerg_reg ? emerg_step : down_step;
         end
         else
         begin
            rate = up_rate;
            step = up_step;
         end
         due      = rate_due(rate, phase_reg, sample_tick);
         vol_next = vol_reg;
         if (vol_reg != goal)
         begin
            if (rate == VRZM_RATE_INSTANT)
               vol_next = goal;
            else if (due)
               vol_next = stepped;
         end
         if (vol_next == goal)
            state_next = VRZM_HOLD;
         else if (goal > vol_next)
            state_next = VRZM_SOFTER;
         else
            state_next = VRZM_LOUDER;
      end

      always_ff @(posedge core_clk)
      begin
         if (reset)
         begin
            vol_reg   <= VRZM_VOL_TARGET_RST;
            state_reg <= VRZM_HOLD;
         end
         else
         begin
            vol_reg   <= vol_next;
            state_reg <= state_next;
         end
      end
   end

   // Any channel still moving
   always_comb
   begin
      active_next = (g_chan[0].state_next != VRZM_HOLD) || (g_chan[1].state_next != VRZM_HOLD);
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
         active_reg <= 1'b0;
      else
         active_reg <= active_next;
   end

   assign reg_rdata        = rdata_reg;
   assign left_volume      = g_chan[0].vol_reg;
   assign right_volume     = g_chan[1].vol_reg;
   assign left_auto_muted  = mute_reg[0];
   assign right_auto_muted = mute_reg[1];
   assign ramp_active      = active_reg;

endmodule
`default_nettype wire

/* File: dv/vrzm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module vrzm_monitor (
   // Clock and reset
   input wire logic       core_clk,
   input wire logic       reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   // Samples and results
   input wire logic       sample_tick,
   input wire logic       left_sample_zero,
   input wire logic [7:0] left_volume,
   input wire logic       left_auto_muted,
   input wire logic       right_auto_muted,
   input wire logic       ramp_active
);
   logic [7:0] ramp_reg;
   logic [7:0] ramp_next;
   logic [7:0] emerg_reg;
   logic [7:0] emerg_next;
   logic [7:0] mute_reg;
   logic [7:0] mute_next;
   logic       slow;

   // Mirror of the controls; slow means no rate field asks for a jump
   always_comb
   begin
      ramp_next  = (reg_wr && reg_addr == 8'h4e) ? reg_wdata : ramp_reg;
      emerg_next = (reg_wr && reg_addr == 8'h4f) ? reg_wdata : emerg_reg;
      mute_next  = (reg_wr && reg_addr == 8'h50) ? reg_wdata : mute_reg;
      slow = ramp_reg[7:6] != 2'h3 && ramp_reg[3:2] != 2'h3 && emerg_reg[7:6] != 2'h3;
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ramp_reg  <= 8'h33;
         emerg_reg <= 8'h30;
         mute_reg  <= 8'h07;
      end
      else
      begin
         ramp_reg  <= ramp_next;
         emerg_reg <= emerg_next;
         mute_reg  <= mute_next;
      end
   end

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);

   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_vol_hold: assert property (
      slow && !$past(sample_tick) |-> $stable(left_volume))
      else $error("volume moved without a sample tick");
   a_step_max: assert property (
      slow && $changed(left_volume) |->
      ((left_volume > $past(left_volume)) ? left_volume - $past(left_volume)
       : $past(left_volume) - left_volume) <= 8'h08)
      else $error("volume step larger than 4 dB");
   a_mute_drop: assert property (
      sample_tick && !left_sample_zero |-> ##3 !left_auto_muted)
      else $error("left mute kept after a nonzero sample");
   a_left_disable: assert property (!mute_reg[0] [*4] |-> !left_auto_muted)
      else $error("left muted while disabled");
   a_right_disable: assert property (!mute_reg[1] [*4] |-> !right_auto_muted)
      else $error("right muted while disabled");
   a_link_both: assert property (
      mute_reg[2] [*4] |-> left_auto_muted == right_auto_muted)
      else $error("linked channels muted apart");
   a_mute_volume: assert property (
      $rose(left_auto_muted) && ramp_reg[7:6] == 2'h3 && emerg_reg[7:6] == 2'h3
      |-> ##[1:3] left_volume == 8'hff)
      else $error("instant mute did not reach the mute code");
   a_reset_vals: assert property (
      $past(reset) |-> left_volume == 8'h30 && !left_auto_muted && !ramp_active)
      else $error("wrong state after reset");
endmodule

bind vrzm_top vrzm_monitor vrzm_monitor_inst (
   .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .sample_tick, .left_sample_zero, .left_volume, .left_auto_muted,
   .right_auto_muted, .ramp_active
);
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       core_clk;
   logic       reset;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       sample_tick;
   logic       left_sample_zero;
   logic       right_sample_zero;
   logic       emergency_ramp;
   logic [7:0] left_volume;
   logic [7:0] right_volume;
   logic       left_auto_muted;
   logic       right_auto_muted;
   logic       ramp_active;
   logic [7:0] ramp_m;
   logic [7:0] emerg_m;
   logic [7:0] d;
   logic       el;
   logic       er;
   int         n_fail;
   int         compares;
   int         seed;
   int         vol [2];
   int         mm [2];
   int         tgt;
   int         ph;
   int         em;
   bit         act;

   vrzm_top vrzm_top_inst (
      .core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sample_tick, .left_sample_zero, .right_sample_zero, .emergency_ramp,
      .left_volume, .right_volume, .left_auto_muted, .right_auto_muted, .ramp_active
   );

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
      @(posedge core_clk);
      #1 check(reg_rdata, 8'h00);
   endtask

   // Back-to-back sample ticks, then time for flags and volume to land
   task automatic tick(input int n, input logic lz, input logic rz);
      repeat (n)
      begin
         @(posedge core_clk);
         sample_tick       <= 1'b1;
         left_sample_zero  <= lz;
         right_sample_zero <= rz;
      end
      @(posedge core_clk);
      sample_tick <= 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
   endtask

   function automatic int nxt(input int v, input int g, input int u);
      if (g > v)
         return (g - v < u) ? g : v + u;
      return (v - g < u) ? g : v - u;
   endfunction

   // Reference ramp for both channels; tk marks one sample period
   task automatic upd(input bit tk);
      int g;
      int r;
      int s;
      act = 1'b0;
      for (int c = 0; c < 2; c++)
      begin
         g = (mm[c] != 0 || em != 0) ? 255 : tgt;
         r = ramp_m[3:2];
         s = ramp_m[1:0];
         if (g > vol[c])
         begin
            r = (em != 0) ? emerg_m[7:6] : ramp_m[7:6];
            s = (em != 0) ? emerg_m[5:4] : ramp_m[5:4];
         end
         if (r == 3)
            vol[c] = g;
         else if (tk && (r == 0 || (r == 1 && ph % 2 == 0) || ph == 0))
            vol[c] = nxt(vol[c], g, 8 >> s);
         act |= vol[c] != g;
      end
      if (tk)
         ph = (ph + 1) % 4;
   endtask

   task automatic cmpv;
      check(left_volume, 8'(vol[0]));
      check(right_volume, 8'(vol[1]));
      check({7'h0, ramp_active}, {7'h0, act});
   endtask

   task automatic settle;
      repeat (3) @(posedge core_clk);
      #1 upd(1'b0);
      cmpv;
      while (act)
      begin
         tick(1, 1'b0, 1'b0);
         upd(1'b1);
         cmpv;
      end
   endtask

   initial
   begin
      repeat (100000) @(posedge core_clk);
      n_fail++;
      complete_run;
   end

   initial
   begin
      seed = 32'hcdd0d5a0;
      n_fail = 0;
      compares = 0;
      reset = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sample_tick = 1'b0;
      left_sample_zero = 1'b0;
      right_sample_zero = 1'b0;
      emergency_ramp = 1'b0;
      vol = '{48, 48};
      mm = '{0, 0};
      tgt = 48;
      ph = 0;
      em = 0;
      ramp_m = 8'h33;
      emerg_m = 8'h30;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      rdc(8'h4c, 8'h30);
      rdc(8'h4e, 8'h33);
      rdc(8'h4f, 8'h30);
      rdc(8'h50, 8'h07);
      rdc(8'h51, 8'h00);
      wr(8'h4d, 8'h5a);
      rdc(8'h4d, 8'h00);
      for (int a = 8'h4e; a < 8'h52; a++)
      begin
         d = 8'($random(seed));
         wr(8'(a), d);
         rdc(8'(a), d);
      end
      $display("test registers done");
      for (int i = 0; i < 32; i++)
      begin
         ramp_m = {i[3:0], i[3:0]};
         tgt = $random(seed) & 255;
         wr(8'h4e, ramp_m);
         wr(8'h4c, 8'(tgt));
         settle;
      end
      $display("test ramp done");
      ramp_m = 8'h00;
      wr(8'h4e, ramp_m);
      for (int i = 0; i < 8; i++)
      begin
         emerg_m = {i[1:0], i[2:1], 4'h0};
         wr(8'h4f, emerg_m);
         @(posedge core_clk);
         emergency_ramp <= 1'b1;
         em = 1;
         settle;
         rdc(8'h52, 8'h10);
         @(posedge core_clk);
         emergency_ramp <= 1'b0;
         em = 0;
         settle;
      end
      $display("test emergency done");
      ramp_m = 8'hcc;
      wr(8'h4e, ramp_m);
      wr(8'h51, 8'h00);
      for (int i = 0; i < 16; i++)
      begin
         tick(1, 1'b0, 1'b0);
         wr(8'h50, {5'h0, i[2:0]});
         tick(1103, 1'b1, i[3]);
         check({7'h0, left_auto_muted | right_auto_muted}, 8'h00);
         tick(1, 1'b1, i[3]);
         el = i[0];
         er = i[1] & i[3];
         if (i[2])
         begin
            el = el & er;
            er = el;
         end
         mm = '{el, er};
         ph = (ph + 1105) % 4;
         upd(1'b0);
         check({7'h0, left_auto_muted}, {7'h0, el});
         check({7'h0, right_auto_muted}, {7'h0, er});
         cmpv;
         rdc(8'h44, 8'(vol[0]));
         rdc(8'h45, 8'(vol[1]));
         rdc(8'h52, {6'h0, er, el});
         mm = '{0, 0};
      end
      $display("test auto mute done");
      complete_run;
   end
endmodule
`default_nettype wire
